// *** slr_map.vh ***
`ifndef SLR_MAP_VH
`define SLR_MAP_VH
// ************************************************************
// frame characters
// ************************************************************
`define SLR_CH_ACK     8'he5
`define SLR_CH_FIX     8'h10
`define SLR_CH_VAR     8'h68
`define SLR_CH_END     8'h16
`define SLR_OWN_ADDR   8'h01
`define SLR_ACD_BIT    5
// ************************************************************
// function codes, master to slave
// ************************************************************
`define SLR_FC_RESET   4'h0
`define SLR_FC_UDATA   4'h3
`define SLR_FC_STATUS  4'h9
`define SLR_FC_CLASS1  4'ha
`define SLR_FC_CLASS2  4'hb
// ************************************************************
// function codes, slave to master
// ************************************************************
`define SLR_RC_ACK     4'h0
`define SLR_RC_NACK    4'h1
`define SLR_RC_DATA    4'h8
`define SLR_RC_NODATA  4'h9
`define SLR_RC_STATUS  4'hb
// ************************************************************
// baud selection and character layout
// ************************************************************
`define SLR_BAUD_300   300
`define SLR_BAUD_600   600
`define SLR_BAUD_1200  1200
`define SLR_BAUD_2400  2400
`define SLR_BAUD_4800  4800
`define SLR_BAUD_9600  9600
`define SLR_CHAR_BITS  4'ha
`define SLR_TX_BITS    4'hb
`define SLR_FIX_LEN    8'h05
`define SLR_VAR_HDR    8'h08
`define SLR_LEN_CA     8'h02
`endif

// *** slr_master_mdl.sv ***
`timescale 1ns/10ps
// ************************************************************
// master station model
// ************************************************************
module slr_master_mdl (
  input  wire clk_in,
  input  wire txd_in,
  output reg  rxd_out
);
  integer   p = 8;
  reg [7:0] rx_q [$];
  initial rxd_out = 1'b1;
  // one rate, start, lsb first, even parity, stop
  task send_byte(input [7:0] b, input bad);
    reg [10:0] sh;
    integer    i;
    begin
      sh = {1'b1, ^b ^ bad, b, 1'b0};
      for (i = 0; i < 11; i = i + 1)
      begin
        @(negedge clk_in) rxd_out = sh[i];
        repeat (p - 1) @(negedge clk_in);
      end
    end
  endtask
  // gathers reply characters until the line idles lim cycles
  task collect(input integer lim);
    reg [9:0] sh;
    integer   n;
    integer   i;
    begin
      rx_q.delete();
      n = 0;
      while (n < lim)
      begin
        @(posedge clk_in);
        n = n + 1;
        if (txd_in === 1'b0)
        begin
          repeat (p / 2) @(posedge clk_in);
          for (i = 0; i < 10; i = i + 1)
          begin
            repeat (p) @(posedge clk_in);
            sh[i] = txd_in;
          end
          // bad parity or stop is kept as unknown so it never matches
          if (sh[9] === 1'b1 && ^sh[8:0] === 1'b0)
            rx_q.push_back(sh[7:0]);
          else
            rx_q.push_back(8'hxx);
          n = 0;
        end
      end
    end
  endtask
endmodule // slr_master_mdl

// *** slr_responder.v ***
// How it works
// R1: the bit period is picked from six rates between 300 and 9600 baud, shared by both ends.
// R2: every character is one start bit, eight data bits, an even parity bit and a stop bit.
// R3: toward the modem only receive, transmit, carrier detect and request to send are used.
// R4: with dial-up enabled, request to send is held asserted all the time.
// R5: with dial-up enabled, carrier detect high opens the receiver to master requests.
// R6: with dial-up disabled, carrier detect is ignored and request to send follows the option.
// R7: function code 0 (reset of remote link) is answered with the single character E5.
// R8: user data with confirm gets E5 or a fixed frame with code 0 (ack) or 1 (nack).
// R9: a link status request (code 9) gets a fixed frame with code 11.
// R10: code 10 asks for class 1 data and code 11 for class 2 data.
// R11: a class request with both queues empty gets the single character E5.
// R12: a class request whose own queue is empty gets a fixed frame with code 9.
// R13: a class request with queued data gets a variable frame with code 8 and the data.
// R14: the application is told of a request only after it arrived without error.
// R15: class 1 is served from the high priority queue and class 2 from the low one.
// R16: the own link address is 1 and only frames for it are answered.
// R17: a frame with a parity, checksum or framing fault is dropped with no reply.
`timescale 1ns/10ps
`include "slr_map.vh"

module slr_responder #(
  parameter CLK_HZ = 250000000
)(
  input  wire        core_clk_in,
  input  wire        resetn_in,
  input  wire [2:0]  baud_sel_in,
  input  wire        dial_en_in,
  input  wire        hs_rts_in,
  input  wire        rxd_in,
  input  wire        dcd_in,
  output wire        txd_out,
  output wire        rts_out,
  output reg         req_ok_out,
  output reg  [3:0]  req_fc_out,
  input  wire        app_reply_valid_in,
  input  wire        app_reply_nack_in,
  input  wire        app_single_ack_in,
  input  wire        hi_q_avail_in,
  input  wire        lo_q_avail_in,
  input  wire [7:0]  hi_q_len_in,
  input  wire [7:0]  lo_q_len_in,
  input  wire [7:0]  user_data_in,
  output wire        user_rd_out,
  output wire        user_hi_out,
  output wire        busy_out
);

  // ************************************************************
  // bit period
  // ************************************************************
  // full-width quotients, cut to the counter width where they are used
  localparam [31:0] DIV_300  = CLK_HZ / `SLR_BAUD_300;
  localparam [31:0] DIV_600  = CLK_HZ / `SLR_BAUD_600;
  localparam [31:0] DIV_1200 = CLK_HZ / `SLR_BAUD_1200;
  localparam [31:0] DIV_2400 = CLK_HZ / `SLR_BAUD_2400;
  localparam [31:0] DIV_4800 = CLK_HZ / `SLR_BAUD_4800;
  localparam [31:0] DIV_9600 = CLK_HZ / `SLR_BAUD_9600;

  reg [19:0] bit_div;
  // R1: rate selection, unknown codes fall back to the fastest rate
  always @*
  begin
    case (baud_sel_in)
      3'h0:    bit_div = DIV_300[19:0];
      3'h1:    bit_div = DIV_600[19:0];
      3'h2:    bit_div = DIV_1200[19:0];
      3'h3:    bit_div = DIV_2400[19:0];
      3'h4:    bit_div = DIV_4800[19:0];
      default: bit_div = DIV_9600[19:0];
    endcase
  end

  // ************************************************************
  // modem lines
  // ************************************************************
  // R4: dial-up keeps rts up; R6: otherwise the handshake option drives it
  assign rts_out = dial_en_in | hs_rts_in;
  // R5: carrier gates the receiver only in dial-up operation
  wire link_ok = ~dial_en_in | dcd_in;

  // ************************************************************
  // character receiver
  // ************************************************************
  reg        rx_busy_ff;
  reg [19:0] rx_cnt_ff;
  reg [3:0]  rx_bit_ff;
  reg [9:0]  rx_sh_ff;
  reg        rx_done_ff;
  reg        rx_err_ff;
  reg [7:0]  rx_byte_ff;

  // R2: sampled mid-bit; parity and stop checked on the last bit
  always @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rx_busy_ff <= 1'b0;
      rx_cnt_ff  <= 20'h00000;
      rx_bit_ff  <= 4'h0;
      rx_sh_ff   <= 10'h000;
      rx_done_ff <= 1'b0;
      rx_err_ff  <= 1'b0;
      rx_byte_ff <= 8'h00;
    end
    else
    begin
      rx_done_ff <= 1'b0;
      if (!rx_busy_ff)
      begin
        if (!rxd_in)
        begin
          rx_busy_ff <= 1'b1;
          rx_cnt_ff  <= {1'b0, bit_div[19:1]};  // half a bit to the centre
          rx_bit_ff  <= 4'h0;
        end
      end
      else if (rx_cnt_ff != 20'h00000)
        rx_cnt_ff <= rx_cnt_ff - 20'h00001;
      else
      begin
        rx_cnt_ff <= bit_div - 20'h00001;
        if (rx_bit_ff == 4'h0 && rxd_in)
          rx_busy_ff <= 1'b0;                   // glitch, not a start bit
        else
        begin
          rx_sh_ff  <= {rxd_in, rx_sh_ff[9:1]};
          rx_bit_ff <= rx_bit_ff + 4'h1;
          if (rx_bit_ff == `SLR_CHAR_BITS)
          begin
            rx_busy_ff <= 1'b0;
            rx_done_ff <= 1'b1;
            rx_byte_ff <= rx_sh_ff[8:1];          // start sits in bit 0, parity in bit 9
            rx_err_ff  <= (^rx_sh_ff[9:1]) | ~rxd_in;
          end
        end
      end
    end
  end

  // ************************************************************
  // frame parser
  // ************************************************************
  localparam [3:0] P_IDLE = 4'h0, P_FC = 4'h1, P_FA = 4'h2, P_FCS = 4'h3, P_END = 4'h4;
  localparam [3:0] P_VL1 = 4'h5, P_VL2 = 4'h6, P_V68 = 4'h7, P_VC = 4'h8, P_VA = 4'h9;
  localparam [3:0] P_VD = 4'ha, P_VCS = 4'hb;

  reg [3:0] ps_ff;
  reg [7:0] sum_ff;
  reg [7:0] len_ff;
  reg [7:0] cnt_ff;
  reg [7:0] ctl_ff;
  reg [7:0] adr_ff;
  reg       frame_ok_ff;
  wire [7:0] b = rx_byte_ff;

  // any faulty character or mismatch returns to idle; a partial frame is simply lost
  always @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ps_ff       <= P_IDLE;
      sum_ff      <= 8'h00;
      len_ff      <= 8'h00;
      cnt_ff      <= 8'h00;
      ctl_ff      <= 8'h00;
      adr_ff      <= 8'h00;
      frame_ok_ff <= 1'b0;
    end
    else
    begin
      frame_ok_ff <= 1'b0;
      if (!link_ok)
        ps_ff <= P_IDLE;
      // R17: parity or framing fault drops the frame
      else if (rx_done_ff && rx_err_ff)
        ps_ff <= P_IDLE;
      else if (rx_done_ff)
      begin
        case (ps_ff)
          P_IDLE:
          begin
            if (b == `SLR_CH_FIX)
              ps_ff <= P_FC;
            else if (b == `SLR_CH_VAR)
              ps_ff <= P_VL1;
          end
          P_FC:
          begin
            ctl_ff <= b;
            sum_ff <= b;
            ps_ff  <= P_FA;
          end
          P_FA:
          begin
            adr_ff <= b;
            sum_ff <= sum_ff + b;
            ps_ff  <= P_FCS;
          end
          P_FCS, P_VCS:
            // R17: checksum fault drops the frame
            ps_ff <= (b == sum_ff) ? P_END : P_IDLE;
          P_END:
          begin
            ps_ff       <= P_IDLE;
            // R16: only the own address gets through
            frame_ok_ff <= (b == `SLR_CH_END) && (adr_ff == `SLR_OWN_ADDR);
          end
          P_VL1:
          begin
            len_ff <= b;
            ps_ff  <= (b < `SLR_LEN_CA) ? P_IDLE : P_VL2;
          end
          P_VL2:
            ps_ff <= (b == len_ff) ? P_V68 : P_IDLE;
          P_V68:
            ps_ff <= (b == `SLR_CH_VAR) ? P_VC : P_IDLE;
          P_VC:
          begin
            ctl_ff <= b;
            sum_ff <= b;
            cnt_ff <= len_ff - `SLR_LEN_CA;
            ps_ff  <= P_VA;
          end
          P_VA:
          begin
            adr_ff <= b;
            sum_ff <= sum_ff + b;
            ps_ff  <= (cnt_ff == 8'h00) ? P_VCS : P_VD;
          end
          P_VD:
          begin
            sum_ff <= sum_ff + b;
            cnt_ff <= cnt_ff - 8'h01;
            if (cnt_ff == 8'h01)
              ps_ff <= P_VCS;
          end
          default:
            ps_ff <= P_IDLE;
        endcase
      end
    end
  end

  // ************************************************************
  // reply sequencer
  // ************************************************************
  localparam [1:0] R_IDLE = 2'h0, R_WAIT = 2'h1, R_SEND = 2'h2;
  localparam [1:0] K_SINGLE = 2'h0, K_FIXED = 2'h1, K_VAR = 2'h2;

  reg [1:0] rs_ff;
  reg [1:0] kind_ff;
  reg [3:0] rfc_ff;
  reg [7:0] dlen_ff;
  reg [7:0] idx_ff;
  reg [7:0] tsum_ff;
  reg       hi_ff;
  reg       tx_busy_ff;
  reg [7:0] tx_byte;
  reg       in_sum;
  reg       is_data;

  wire [3:0] fc       = ctl_ff[3:0];
  wire       cls_hi   = (fc == `SLR_FC_CLASS1);
  // R15: class 1 reads the high priority queue, class 2 the low one
  wire       cls_av   = cls_hi ? hi_q_avail_in : lo_q_avail_in;
  wire [7:0] cls_len  = cls_hi ? hi_q_len_in : lo_q_len_in;
  wire [7:0] ctl_out  = {2'b00, hi_q_avail_in, 1'b0, rfc_ff};  // acd flags class 1 data
  wire [7:0] last_idx = (kind_ff == K_SINGLE) ? 8'h00 :
                        (kind_ff == K_FIXED) ? (`SLR_FIX_LEN - 8'h01) :
                        (dlen_ff + `SLR_VAR_HDR - 8'h01);
  wire       tx_load  = (rs_ff == R_SEND) && !tx_busy_ff;

  assign user_rd_out = tx_load && is_data;
  assign user_hi_out = hi_ff;
  assign busy_out    = (rs_ff != R_IDLE);

  // byte at the current position of the reply
  always @*
  begin
    tx_byte = `SLR_CH_ACK;
    in_sum  = 1'b0;
    is_data = 1'b0;
    if (kind_ff == K_FIXED)
    begin
      case (idx_ff)
        8'h00:   tx_byte = `SLR_CH_FIX;
        8'h01:   begin tx_byte = ctl_out; in_sum = 1'b1; end
        8'h02:   begin tx_byte = `SLR_OWN_ADDR; in_sum = 1'b1; end
        8'h03:   tx_byte = tsum_ff;
        default: tx_byte = `SLR_CH_END;
      endcase
    end
    else if (kind_ff == K_VAR)
    begin
      if (idx_ff == 8'h00 || idx_ff == 8'h03)
        tx_byte = `SLR_CH_VAR;
      else if (idx_ff == 8'h01 || idx_ff == 8'h02)
        tx_byte = dlen_ff + `SLR_LEN_CA;
      else if (idx_ff == 8'h04)
      begin
        tx_byte = ctl_out;
        in_sum  = 1'b1;
      end
      else if (idx_ff == 8'h05)
      begin
        tx_byte = `SLR_OWN_ADDR;
        in_sum  = 1'b1;
      end
      else if (idx_ff == last_idx)
        tx_byte = `SLR_CH_END;
      else if (idx_ff == last_idx - 8'h01)
        tx_byte = tsum_ff;
      else
      begin
        tx_byte = user_data_in;
        in_sum  = 1'b1;
        is_data = 1'b1;
      end
    end
  end

  // choose the reply for each good frame, then walk its bytes
  always @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rs_ff      <= R_IDLE;
      kind_ff    <= K_SINGLE;
      rfc_ff     <= 4'h0;
      dlen_ff    <= 8'h00;
      idx_ff     <= 8'h00;
      tsum_ff    <= 8'h00;
      hi_ff      <= 1'b0;
      req_ok_out <= 1'b0;
      req_fc_out <= 4'h0;
    end
    else
    begin
      req_ok_out <= 1'b0;
      case (rs_ff)
        R_IDLE:
        begin
          idx_ff  <= 8'h00;
          tsum_ff <= 8'h00;
          if (frame_ok_ff)
          begin
            // R14: the application hears only of error-free frames
            req_ok_out <= 1'b1;
            req_fc_out <= fc;
            case (fc)
              // R7: reset of remote link
              `SLR_FC_RESET:
              begin
                kind_ff <= K_SINGLE;
                rs_ff   <= R_SEND;
              end
              // R8: the application supplies ack or nack
              `SLR_FC_UDATA:
                rs_ff <= R_WAIT;
              // R9: status of link
              `SLR_FC_STATUS:
              begin
                kind_ff <= K_FIXED;
                rfc_ff  <= `SLR_RC_STATUS;
                rs_ff   <= R_SEND;
              end
              // R10: class 1 and class 2 data requests
              `SLR_FC_CLASS1, `SLR_FC_CLASS2:
              begin
                hi_ff <= cls_hi;
                rs_ff <= R_SEND;
                // R11: nothing in either queue
                if (!hi_q_avail_in && !lo_q_avail_in)
                  kind_ff <= K_SINGLE;
                // R12: requested queue empty
                else if (!cls_av || cls_len == 8'h00)
                begin
                  kind_ff <= K_FIXED;
                  rfc_ff  <= `SLR_RC_NODATA;
                end
                // R13: user data frame
                else
                begin
                  kind_ff <= K_VAR;
                  rfc_ff  <= `SLR_RC_DATA;
                  dlen_ff <= cls_len;
                end
              end
              default:
                rs_ff <= R_IDLE;  // unsupported codes get no answer
            endcase
          end
        end
        R_WAIT:
          // R8: single ack or fixed frame with code 0 or 1
          if (app_reply_valid_in)
          begin
            rs_ff   <= R_SEND;
            kind_ff <= (app_single_ack_in && !app_reply_nack_in) ? K_SINGLE : K_FIXED;
            rfc_ff  <= app_reply_nack_in ? `SLR_RC_NACK : `SLR_RC_ACK;
          end
        R_SEND:
          if (tx_load)
          begin
            if (in_sum)
              tsum_ff <= tsum_ff + tx_byte;
            idx_ff <= idx_ff + 8'h01;
            if (idx_ff == last_idx)
              rs_ff <= R_IDLE;
          end
        default:
          rs_ff <= R_IDLE;
      endcase
    end
  end

  // ************************************************************
  // character transmitter
  // ************************************************************
  reg [19:0] tx_cnt_ff;
  reg [3:0]  tx_bit_ff;
  reg [10:0] tx_sh_ff;

  // R3: only the transmit line leaves here besides rts
  assign txd_out = tx_sh_ff[0];

  // R2: stop, even parity, data lsb first, start
  always @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      tx_busy_ff <= 1'b0;
      tx_cnt_ff  <= 20'h00000;
      tx_bit_ff  <= 4'h0;
      tx_sh_ff   <= 11'h7ff;
    end
    else if (tx_load)
    begin
      tx_busy_ff <= 1'b1;
      tx_cnt_ff  <= bit_div - 20'h00001;
      tx_bit_ff  <= 4'h0;
      tx_sh_ff   <= {1'b1, ^tx_byte, tx_byte, 1'b0};
    end
    else if (tx_busy_ff)
    begin
      if (tx_cnt_ff != 20'h00000)
        tx_cnt_ff <= tx_cnt_ff - 20'h00001;
      else
      begin
        tx_cnt_ff <= bit_div - 20'h00001;
        tx_sh_ff  <= {1'b1, tx_sh_ff[10:1]};
        tx_bit_ff <= tx_bit_ff + 4'h1;
        if (tx_bit_ff == `SLR_TX_BITS - 4'h1)
          tx_busy_ff <= 1'b0;
      end
    end
  end

endmodule // slr_responder

// *** slr_responder_chk.sv ***
`timescale 1ns/10ps
// ************************************************************
// port checker for the link responder
// ************************************************************
module slr_chk (
  input wire       core_clk_in,
  input wire       resetn_in,
  input wire       dial_en_in,
  input wire       hs_rts_in,
  input wire       dcd_in,
  input wire       txd_out,
  input wire       rts_out,
  input wire       req_ok_out,
  input wire [3:0] req_fc_out,
  input wire       user_rd_out,
  input wire       user_hi_out,
  input wire       busy_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);
  // runs of 8 cycles: the bench never goes faster than 8 cycles a bit
  sequence s_low_run;
    (!txd_out) [*8];
  endsequence
  sequence s_high_run;
    txd_out [*8];
  endsequence
  sequence s_known_req;
    req_ok_out && (req_fc_out == 4'h0 || req_fc_out == 4'h9);
  endsequence
  AST_RTS_LEVEL: assert property (rts_out == (dial_en_in | hs_rts_in))
    else $error("rts level wrong");
  AST_LOW_BIT: assert property ($fell(txd_out) |-> s_low_run)
    else $error("short low bit");
  AST_HIGH_BIT: assert property ($rose(txd_out) |-> s_high_run)
    else $error("short high bit");
  AST_REQ_PULSE: assert property (req_ok_out |=> !req_ok_out)
    else $error("request pulse too long");
  AST_BUSY_ANS: assert property (s_known_req |-> ##[0:1] busy_out)
    else $error("no reply started");
  AST_STATUS_TX: assert property (req_ok_out && req_fc_out == 4'h9 |-> ##[1:3] !txd_out)
    else $error("status reply late");
  AST_UNKNOWN: assert property (req_ok_out && req_fc_out == 4'h4 |=> (!busy_out && txd_out) [*8])
    else $error("unknown code answered");
  AST_DCD_GATE: assert property (req_ok_out && dial_en_in |-> dcd_in)
    else $error("request taken without carrier");
  AST_RD_BUSY: assert property (user_rd_out |-> busy_out)
    else $error("data read while idle");
  AST_RD_CLASS: assert property (user_rd_out |-> (user_hi_out == (req_fc_out == 4'ha)))
    else $error("wrong queue read");
endmodule // slr_chk

bind slr_responder slr_chk chk_u (
  .core_clk_in (core_clk_in),
  .resetn_in   (resetn_in),
  .dial_en_in  (dial_en_in),
  .hs_rts_in   (hs_rts_in),
  .dcd_in      (dcd_in),
  .txd_out     (txd_out),
  .rts_out     (rts_out),
  .req_ok_out  (req_ok_out),
  .req_fc_out  (req_fc_out),
  .user_rd_out (user_rd_out),
  .user_hi_out (user_hi_out),
  .busy_out    (busy_out)
);

// *** slr_responder_tb.sv ***
`timescale 1ns/10ps
module slr_responder_tb;
  reg        clk = 1'b0;
  reg        rstn = 1'b0;
  reg  [2:0] baud = 3'h5;
  reg        dial = 1'b0;
  reg        hs = 1'b0;
  reg        dcd = 1'b0;
  reg        a_vld = 1'b0;
  reg        a_nack = 1'b0;
  reg        a_one = 1'b0;
  reg        hi_av = 1'b0;
  reg        lo_av = 1'b0;
  reg  [7:0] hi_len = 8'h00;
  reg  [7:0] lo_len = 8'h00;
  reg  [7:0] udata = 8'h00;
  wire       rxd, txd, rts, req_ok, urd, uhi, busy;
  wire [3:0] req_fc;
  reg [31:0] seed = 32'd29;
  reg  [7:0] dat [0:255];
  reg  [7:0] exp_q [$];
  reg  [7:0] n, e_n;
  reg        av;
  integer    n_fail = 0;
  integer    tests_run = 0;
  integer    idx = 0;
  integer    n_req = 0;
  integer    p = 8;
  integer    k;
  integer    j;

  initial forever #2 clk = ~clk;

  slr_master_mdl m_u (.clk_in(clk), .txd_in(txd), .rxd_out(rxd));

  // small clock so that 300 baud is 256 cycles a bit
  slr_responder #(.CLK_HZ(76800)) dut_u (
    .core_clk_in(clk), .resetn_in(rstn), .baud_sel_in(baud), .dial_en_in(dial),
    .hs_rts_in(hs), .rxd_in(rxd), .dcd_in(dcd), .txd_out(txd), .rts_out(rts),
    .req_ok_out(req_ok), .req_fc_out(req_fc), .app_reply_valid_in(a_vld),
    .app_reply_nack_in(a_nack), .app_single_ack_in(a_one), .hi_q_avail_in(hi_av),
    .lo_q_avail_in(lo_av), .hi_q_len_in(hi_len), .lo_q_len_in(lo_len),
    .user_data_in(udata), .user_rd_out(urd), .user_hi_out(uhi), .busy_out(busy));

  // queue feed: next byte shown after each pop
  always @(negedge clk) udata <= dat[idx[7:0]];
  always @(posedge clk) if (urd === 1'b1) idx <= idx + 1;
  always @(posedge clk) if (req_ok === 1'b1) n_req <= n_req + 1;

  function [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed;
  endfunction
  function [7:0] ctl(input [3:0] fc);
    ctl = {2'b00, hi_av, 1'b0, fc};
  endfunction
  task exp_fix(input [3:0] fc);
    exp_q = {8'h10, ctl(fc), 8'h01, ctl(fc) + 8'h01, 8'h16};
  endtask
  task exp_var(input [7:0] cnt);
    reg [7:0] cs;
    reg [7:0] l;
    integer   i;
    begin
      l = cnt + 8'h02;
      cs = ctl(4'h8) + 8'h01;
      exp_q = {8'h68, l, l, 8'h68, ctl(4'h8), 8'h01};
      for (i = 0; i < cnt; i = i + 1)
      begin
        exp_q.push_back(dat[i]);
        cs = cs + dat[i];
      end
      exp_q.push_back(cs);
      exp_q.push_back(8'h16);
    end
  endtask
  task chk_val(input [7:0] e, input [7:0] g);
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      n_fail = n_fail + 1;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task chk_frame();
    integer i;
    begin
      chk_val(8'(exp_q.size()), 8'(m_u.rx_q.size()));
      for (i = 0; i < exp_q.size() && i < m_u.rx_q.size(); i = i + 1)
        chk_val(exp_q[i], m_u.rx_q[i]);
    end
  endtask
  // one request, the reply gathered from the start of its last char
  task run(input [7:0] c, input [7:0] a, input bad, input vr);
    reg [7:0] f [$];
    reg [7:0] d;
    integer   i;
    begin
      d = 8'(rnd());
      n_req = 0;
      idx = 0;
      if (vr)
        f = {8'h68, 8'h03, 8'h03, 8'h68, c, a, d, 8'(c + a + d), 8'h16};
      else
        f = {8'h10, c, a, 8'(c + a), 8'h16};
      for (i = 0; i < f.size() - 1; i = i + 1)
        m_u.send_byte(f[i], bad && i == 3);
      fork
        m_u.send_byte(8'h16, 1'b0);
        m_u.collect(16 * p);
      join
      @(negedge clk);
      $display("test c=%h a=%h done", c, a);
    end
  endtask
  task wrap_up();
    $display("checks %0d fails %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (90000) @(posedge clk);
    n_fail = n_fail + 1;
    wrap_up();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    for (k = 0; k < 4; k = k + 1)
    begin
      @(negedge clk) {hs, dial} = k[1:0];
      @(posedge clk);
      chk_val({7'h00, rts}, {7'h00, k[0] | k[1]});
    end
    chk_val({5'h00, txd, busy, req_ok}, 8'h04);
    @(negedge clk) rstn = 1'b1;
    {dial, hs} = 2'b00;
    for (k = 0; k < 6; k = k + 1)
    begin
      @(negedge clk) baud = k[2:0];
      p = 256 >> k;
      m_u.p = p;
      run(8'h40, 8'h01, 1'b0, 1'b0);
      exp_q = {8'he5};
      chk_frame();
      chk_val(8'(n_req), 8'h01);
      chk_val({4'h0, req_fc}, 8'h00);
    end
    for (j = 0; j < 2; j = j + 1)
    begin
      hi_av = j[0];
      run(8'h49, 8'h01, 1'b0, 1'b0);
      exp_fix(4'hb);
      chk_frame();
    end
    for (j = 0; j < 3; j = j + 1)
    begin
      {a_vld, a_nack, a_one} = {1'b1, j == 0, j == 1};
      run(8'h43, 8'h01, 1'b0, 1'b1);
      a_vld = 1'b0;
      if (j == 1)
        exp_q = {8'he5};
      else
        exp_fix(j == 0 ? 4'h1 : 4'h0);
      chk_frame();
    end
    for (j = 0; j < 8; j = j + 1)
    begin
      for (k = 0; k < 8; k = k + 1)
        dat[k] = 8'(rnd());
      {lo_av, hi_av} = j[2:1];
      n = (j == 6) ? 8'h00 : 8'h01 + 8'(rnd() & 3);
      hi_len = n;
      lo_len = n + 8'h01;
      av = j[0] ? lo_av : hi_av;
      if (j[0])
        n = lo_len;
      run(j[0] ? 8'h4b : 8'h4a, 8'h01, 1'b0, 1'b0);
      e_n = 8'h00;
      if (!hi_av && !lo_av)
        exp_q = {8'he5};
      else if (!av || n == 8'h00)
        exp_fix(4'h9);
      else
        e_n = n;
      if (e_n != 8'h00)
        exp_var(e_n);
      chk_frame();
      chk_val(8'(idx), e_n);
      chk_val({7'h00, uhi}, {7'h00, !j[0]});
    end
    run(8'h40, 8'h02, 1'b0, 1'b0);
    exp_q = {};
    chk_frame();
    chk_val(8'(n_req), 8'h00);
    run(8'h40, 8'h01, 1'b1, 1'b0);
    chk_frame();
    chk_val(8'(n_req), 8'h00);
    run(8'h44, 8'h01, 1'b0, 1'b0);
    chk_frame();
    chk_val(8'(n_req), 8'h01);
    {dial, hs, dcd} = 3'b100;
    run(8'h40, 8'h01, 1'b0, 1'b0);
    chk_frame();
    chk_val(8'(n_req), 8'h00);
    dcd = 1'b1;
    run(8'h40, 8'h01, 1'b0, 1'b0);
    exp_q = {8'he5};
    chk_frame();
    chk_val({7'h00, rts}, 8'h01);
    wrap_up();
  end
endmodule // slr_responder_tb
